// >>> core/orss_seq.sv
// Purpose: start-up sequencer with soft-start ramp and digital servo
// Assumes: comparator, ADC and fault flags arrive asynchronously
// Notes:   wait, ramp, timeout and servo timing runs from ticks seen on the shared timebase line; the fault filter counts clock cycles
//
// Operation
// - Hold run line low until initialized and supply above start threshold.
// - On a shared run line, keep pulling low until this device is ready.
// - After run line release, count turn_on_wait ticks before ramping.
// - Time derives from timebase line; the fastest driver sets the ticks.
// - Soft-start steps the target digitally from zero to the set point.
// - A ramp_duration below 0.25 ms skips the soft-start ramp.
// - One target step per 0.1 ms tick; steps equal duration over tick.
// - Force discontinuous conduction throughout the soft-start ramp.
// - In discontinuous mode turn low_side_switch off on reverse current.
// - Fault pin may release once output exceeds output_low_threshold.
// - fault_pin_routing bit 12 selects the unfiltered undervoltage source.
// - Fault pin input passes a 250 us deglitch filter.
// - converter_mode_cfg bit 6 enables the digital servo loop.
// - Servo moves DAC one LSB per 90 ms; bit 1 selects LSB size.
// - Servo engages after ramp_timeout_limit; zero means no timeout.
// - Zero limit: start after ramp, output above threshold, no overcurrent.
// - Servo start switches from forced discontinuous to bit 0 mode.
// - Ignore action: ramp done, limit expired, output good or no overcurrent.
// - Other action: ramp done, limit expired, no low or overcurrent fault.
// - ramp_duration is limited to 1.3 seconds.
`timescale 1ns/100ps

`include "orss_regs.svh"

module orss_seq #(
  parameter int TICK_CYCLES =
    (`ORSS_TICK_NS + `ORSS_CLK_NS - 1) / `ORSS_CLK_NS,
  parameter int FLT_CYCLES =
    (`ORSS_FLT_NS + `ORSS_CLK_NS - 1) / `ORSS_CLK_NS,
  parameter int TB_LOW_CYCLES =
    (`ORSS_TB_LOW_NS + `ORSS_CLK_NS - 1) / `ORSS_CLK_NS
) (
  input wire logic mclk,
  input wire logic reset,
  input wire orss_pkg::orss_bus_t bus,
  output logic [31:0] rdata,
  input wire orss_pkg::orss_in_t pins,
  output logic run_oe,
  output logic timebase_oe,
  output logic fault_oe,
  output logic [15:0] target,
  output logic [11:0] dac_trim,
  output logic lsb_fine,
  output logic force_dcm,
  output logic ccm_mode,
  output logic low_side_off,
  output logic servo_on
);
  import orss_pkg::*;

  localparam logic [15:0] TICK_N = 16'(TICK_CYCLES);
  localparam logic [15:0] FLT_N = 16'(FLT_CYCLES);
  localparam logic [15:0] TB_LOW_N = 16'(TB_LOW_CYCLES);

  // Counters are 16 bits wide
  initial begin
    if (TICK_CYCLES < 4 || TICK_CYCLES > 65535 || FLT_CYCLES < 1 ||
        FLT_CYCLES > 65535 || TB_LOW_CYCLES < 1 ||
        TB_LOW_CYCLES >= TICK_CYCLES) begin
      $error("orss_seq: timing parameters out of range");
    end
  end

  // Ramp steps from the programmed duration, capped at 1.3 s
  function automatic logic [15:0] ramp_steps(input logic [15:0] dur);
    ramp_steps = (dur > `ORSS_RAMP_MAX_TICKS) ?
      `ORSS_RAMP_MAX_TICKS : dur;
  endfunction

  // Servo start condition across the three timeout settings
  function automatic logic servo_ready(input orss_st_t s);
    if (s.to_limit == 16'h0000) begin
      servo_ready = s.in2.vout_above && !s.in2.oc_active;
    end else if (s.to_action == `ORSS_ACTION_IGNORE) begin
      servo_ready = s.to_exp &&
        (s.in2.vout_above || !s.in2.oc_active);
    end else begin
      servo_ready = s.to_exp && !s.in2.uv_fault &&
        !s.in2.oc_active;
    end
  endfunction

  orss_st_t q;
  orss_st_t d;
  logic [15:0] steps;
  logic [16:0] r_sh;
  logic [16:0] acc_n;
  logic [15:0] tgt_n;
  logic tb_fall;

  ////////////////////////////////////////////////////////////////////////
  // Next state of the whole block
  always_comb begin
    d = q;
    steps = ramp_steps(q.ramp_duration);
    r_sh = {q.div_rem, q.quo[15]};
    acc_n = q.acc + {1'b0, q.div_rem};
    tgt_n = q.target + q.quo;

    // Two-stage synchronisers for every outside input
    d.in1 = pins;
    d.in2 = q.in1;

    // Falling edge of the shared line is the tick; own divider restarts
    // on each falling edge so the fastest device on the line sets the pace
    tb_fall = q.tb_prev && !q.in2.timebase;
    d.tb_prev = q.in2.timebase;
    d.tick = tb_fall;
    if (tb_fall || q.tb_div == TICK_N - 16'h0001) begin
      d.tb_div = 16'h0000;
    end else begin
      d.tb_div = q.tb_div + 16'h0001;
    end
    d.tb_oe = (q.tb_div == TICK_N - 16'h0001) ||
      (q.tb_oe && q.tb_div < TB_LOW_N);

    // Deglitch of the fault pin level
    if (q.in2.fault_pin == q.flt_lvl) begin
      d.flt_cnt = 16'h0000;
    end else if (q.flt_cnt == FLT_N - 16'h0001) begin
      d.flt_cnt = 16'h0000;
      d.flt_lvl = q.in2.fault_pin;
    end else begin
      d.flt_cnt = q.flt_cnt + 16'h0001;
    end

    // Fault pin pulls low while the chosen undervoltage source is active
    if (q.routing[`ORSS_B_ROUTE_UNFILT]) begin
      d.fault_oe = !q.in2.vout_above;
    end else begin
      d.fault_oe = q.in2.uv_fault;
    end

    // Timeout counter runs from the start of the ramp
    if (q.st == ST_INIT || q.st == ST_WAIT_RUN || q.st == ST_DELAY) begin
      d.to_cnt = 16'h0000;
      d.to_exp = 1'b0;
    end else begin
      if (q.tick && !q.to_exp) begin
        d.to_cnt = q.to_cnt + 16'h0001;
      end
      d.to_exp = q.to_limit != 16'h0000 && q.to_cnt >= q.to_limit;
    end

    // Reverse current cuts the low side switch in discontinuous mode
    d.ls_off = (q.force_dcm || !q.mode_cfg[`ORSS_B_CCM]) &&
      q.in2.rev_current;

    // Run line drive follows own readiness only
    d.run_oe = !(q.in2.init_done && q.in2.supply_ok);

    case (q.st)
      ST_INIT: begin
        d.target = 16'h0000;
        d.force_dcm = 1'b1;
        d.servo_on = 1'b0;
        if (q.in2.init_done && q.in2.supply_ok) begin
          d.st = ST_WAIT_RUN;
        end
      end
      ST_WAIT_RUN: begin
        // Shared line rises only when every device has let go
        d.cnt = 16'h0000;
        if (!(q.in2.init_done && q.in2.supply_ok)) begin
          d.st = ST_INIT;
        end else if (q.in2.run_line) begin
          d.st = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (!q.in2.run_line) begin
          d.st = ST_INIT;
        end else if (q.cnt >= q.turn_on_wait) begin
          d.st = ST_PREP;
          d.cnt = 16'h0000;
          d.quo = q.set_point;
          d.div_rem = 16'h0000;
          d.div_i = 5'h00;
        end else if (q.tick) begin
          d.cnt = q.cnt + 16'h0001;
        end
      end
      ST_PREP: begin
        // Serial divide of set point by step count, one bit a cycle
        if (q.div_i != 5'h10) begin
          d.div_i = q.div_i + 5'h01;
          if (r_sh >= {1'b0, steps}) begin
            d.div_rem = 16'(r_sh - {1'b0, steps});
            d.quo = {q.quo[14:0], 1'b1};
          end else begin
            d.div_rem = r_sh[15:0];
            d.quo = {q.quo[14:0], 1'b0};
          end
        end else if (steps < `ORSS_SKIP_TICKS) begin
          d.target = q.set_point;
          d.st = ST_SETTLE;
        end else begin
          d.acc = 17'h00000;
          d.st = ST_RAMP;
        end
      end
      ST_RAMP: begin
        d.force_dcm = 1'b1;
        if (q.tick) begin
          // Quotient each tick plus a carried remainder share
          if (acc_n >= {1'b0, steps}) begin
            d.acc = 17'(acc_n - {1'b0, steps});
            d.target = tgt_n + 16'h0001;
          end else begin
            d.acc = acc_n;
            d.target = tgt_n;
          end
          d.cnt = q.cnt + 16'h0001;
          if (q.cnt == steps - 16'h0001) begin
            d.st = ST_SETTLE;
          end
        end
      end
      ST_SETTLE: begin
        if (servo_ready(q)) begin
          d.st = ST_RUN;
          d.force_dcm = 1'b0;
          d.servo_on = q.mode_cfg[`ORSS_B_SERVO_EN];
          d.servo_cnt = 16'h0000;
        end
      end
      ST_RUN: begin
        d.servo_on = q.mode_cfg[`ORSS_B_SERVO_EN];
        if (q.tick) begin
          if (q.servo_cnt == `ORSS_SERVO_TICKS - 16'h0001) begin
            d.servo_cnt = 16'h0000;
            if (q.servo_on && q.in2.adc_low) begin
              d.trim = q.trim + 12'h001;
            end else if (q.servo_on && q.in2.adc_high) begin
              d.trim = q.trim - 12'h001;
            end
          end else begin
            d.servo_cnt = q.servo_cnt + 16'h0001;
          end
        end
      end
      default: begin
        d.st = ST_INIT;
      end
    endcase

    // Loss of supply or init drops back and rearms the sequence
    if (q.st != ST_INIT && !(q.in2.init_done && q.in2.supply_ok)) begin
      d.st = ST_INIT;
      d.target = 16'h0000;
      d.force_dcm = 1'b1;
      d.servo_on = 1'b0;
      d.trim = 12'h000;
    end

    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        `ORSS_A_MODE_CFG: d.mode_cfg = bus.wdata[15:0];
        `ORSS_A_TURN_ON_WAIT: d.turn_on_wait = bus.wdata[15:0];
        `ORSS_A_RAMP_DURATION: d.ramp_duration = bus.wdata[15:0];
        `ORSS_A_SET_POINT: d.set_point = bus.wdata[15:0];
        `ORSS_A_TIMEOUT_LIMIT: d.to_limit = bus.wdata[15:0];
        `ORSS_A_TIMEOUT_ACTION: d.to_action = bus.wdata[7:0];
        `ORSS_A_FAULT_ROUTING: d.routing = bus.wdata[15:0];
        default: begin
        end
      endcase
    end

    // Mode pin from next values, so the output is a plain flop
    d.ccm = d.mode_cfg[`ORSS_B_CCM] && !d.force_dcm;

    // Register reads; unmapped offsets answer zero
    if (bus.rd) begin
      case (bus.addr)
        `ORSS_A_MODE_CFG: d.rdata = {16'h0000, q.mode_cfg};
        `ORSS_A_TURN_ON_WAIT: d.rdata = {16'h0000, q.turn_on_wait};
        `ORSS_A_RAMP_DURATION: d.rdata = {16'h0000, q.ramp_duration};
        `ORSS_A_SET_POINT: d.rdata = {16'h0000, q.set_point};
        `ORSS_A_TIMEOUT_LIMIT: d.rdata = {16'h0000, q.to_limit};
        `ORSS_A_TIMEOUT_ACTION: d.rdata = {24'h000000, q.to_action};
        `ORSS_A_FAULT_ROUTING: d.rdata = {16'h0000, q.routing};
        `ORSS_A_STATUS: d.rdata = {q.trim, 10'h000, q.st, q.flt_lvl,
          q.to_exp, q.servo_on, q.force_dcm, q.fault_oe, q.run_oe,
          q.in2.run_line};
        `ORSS_A_TARGET: d.rdata = {16'h0000, q.target};
        default: d.rdata = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; reset is synchronous
  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '0;
      q.st <= ST_INIT;
      q.run_oe <= 1'b1;
      q.force_dcm <= 1'b1;
      q.in1.timebase <= 1'b1;
      q.in2.timebase <= 1'b1;
      q.tb_prev <= 1'b1;
      q.in1.fault_pin <= 1'b1;
      q.in2.fault_pin <= 1'b1;
      q.flt_lvl <= 1'b1;
      q.mode_cfg <= `ORSS_RST_MODE_CFG;
      q.turn_on_wait <= `ORSS_RST_TURN_ON_WAIT;
      q.ramp_duration <= `ORSS_RST_RAMP_DURATION;
      q.set_point <= `ORSS_RST_SET_POINT;
      q.to_limit <= `ORSS_RST_TIMEOUT_LIMIT;
      q.to_action <= `ORSS_RST_TIMEOUT_ACTION;
      q.routing <= `ORSS_RST_FAULT_ROUTING;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign rdata = q.rdata;
  assign run_oe = q.run_oe;
  assign timebase_oe = q.tb_oe;
  assign fault_oe = q.fault_oe;
  assign target = q.target;
  assign dac_trim = q.trim;
  assign lsb_fine = q.mode_cfg[`ORSS_B_LSB_FINE];
  assign force_dcm = q.force_dcm;
  assign ccm_mode = q.ccm;
  assign low_side_off = q.ls_off;
  assign servo_on = q.servo_on;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  AST_RUN_HOLD: assert property (
    !(q.in2.init_done && q.in2.supply_ok) |=> run_oe)
    else $error("run line released before ready");

  AST_DELAY_ZERO: assert property (
    q.st == ST_DELAY |-> target == 16'h0000)
    else $error("target moved during turn-on wait");

  AST_TICK_EDGE: assert property (
    (q.tb_prev && !q.in2.timebase) |=> q.tick ##1 !q.tick)
    else $error("tick not taken from timebase edge");

  AST_RAMP_DCM: assert property (
    q.st == ST_RAMP |-> force_dcm && !ccm_mode)
    else $error("ramp without forced discontinuous mode");

  AST_LS_OFF: assert property (
    (force_dcm && q.in2.rev_current) |=> low_side_off)
    else $error("low side switch not cut on reverse current");

  AST_SKIP: assert property (
    (q.st == ST_PREP && q.div_i == 5'h10 &&
      ramp_steps(q.ramp_duration) < `ORSS_SKIP_TICKS)
      |=> q.st == ST_SETTLE && target == $past(q.set_point))
    else $error("short ramp not skipped");

  AST_RAMP_END: assert property (
    (q.st == ST_RAMP ##1 q.st == ST_SETTLE) |-> target == q.set_point)
    else $error("ramp did not end on set point");

  AST_MODE_SWITCH: assert property (
    (q.st == ST_SETTLE ##1 q.st == ST_RUN) |-> !force_dcm)
    else $error("mode not released at servo start");

  AST_ZERO_LIMIT: assert property (
    (q.st == ST_SETTLE && q.to_limit == 16'h0000 && q.in2.vout_above &&
      !q.in2.oc_active && q.in2.init_done && q.in2.supply_ok)
      |=> q.st == ST_RUN)
    else $error("servo start missed with zero limit");

  AST_FAULT_ROUTE: assert property (
    (q.routing[`ORSS_B_ROUTE_UNFILT] && q.in2.vout_above) |=> !fault_oe)
    else $error("fault pin not released by unfiltered source");

endmodule

// >>> core/orss_regs.svh
// Purpose: register offsets, reset values and timing figures of the
//          output ramp sequencer
// Assumes: 32-bit register port, one aligned word per register
// Notes:   times are in ns, except servo period, skip limit and ramp cap, which are in ticks; cycle counts are derived in the module
`ifndef ORSS_REGS_SVH
`define ORSS_REGS_SVH

`define ORSS_CLK_NS 4
`define ORSS_TICK_NS 100000
`define ORSS_FLT_NS 250000
`define ORSS_TB_LOW_NS 500
`define ORSS_SERVO_TICKS 16'h0384
`define ORSS_SKIP_TICKS 16'h0003
`define ORSS_RAMP_MAX_TICKS 16'h32C8

`define ORSS_A_MODE_CFG 8'h00
`define ORSS_A_TURN_ON_WAIT 8'h04
`define ORSS_A_RAMP_DURATION 8'h08
`define ORSS_A_SET_POINT 8'h0C
`define ORSS_A_TIMEOUT_LIMIT 8'h10
`define ORSS_A_TIMEOUT_ACTION 8'h14
`define ORSS_A_FAULT_ROUTING 8'h18
`define ORSS_A_STATUS 8'h1C
`define ORSS_A_TARGET 8'h20

`define ORSS_B_CCM 0
`define ORSS_B_LSB_FINE 1
`define ORSS_B_SERVO_EN 6
`define ORSS_B_ROUTE_UNFILT 12
`define ORSS_ACTION_IGNORE 8'h00

`define ORSS_RST_MODE_CFG 16'h0001
`define ORSS_RST_TURN_ON_WAIT 16'h0000
`define ORSS_RST_RAMP_DURATION 16'h0050
`define ORSS_RST_SET_POINT 16'h0000
`define ORSS_RST_TIMEOUT_LIMIT 16'h0000
`define ORSS_RST_TIMEOUT_ACTION 8'h00
`define ORSS_RST_FAULT_ROUTING 16'h0000

`endif

// >>> core/orss_pkg.sv
// Purpose: types of the output ramp sequencer
// Assumes: constants live in orss_regs.svh
// Notes:   one packed struct holds the whole module state
package orss_pkg;

  typedef enum logic [2:0] {
    ST_INIT, ST_WAIT_RUN, ST_DELAY, ST_PREP, ST_RAMP, ST_SETTLE, ST_RUN
  } orss_state_t;

  // Inputs from outside the clock domain
  typedef struct packed {
    logic init_done;
    logic supply_ok;
    logic run_line;
    logic timebase;
    logic fault_pin;
    logic vout_above;
    logic uv_fault;
    logic oc_active;
    logic rev_current;
    logic adc_low;
    logic adc_high;
  } orss_in_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } orss_bus_t;

  typedef struct packed {
    orss_in_t in1;
    orss_in_t in2;
    logic tb_prev;
    orss_state_t st;
    logic [15:0] tb_div;
    logic tick;
    logic [15:0] cnt;
    logic [15:0] to_cnt;
    logic to_exp;
    logic [15:0] servo_cnt;
    logic [15:0] quo;
    logic [15:0] div_rem;
    logic [16:0] acc;
    logic [4:0] div_i;
    logic [15:0] target;
    logic [11:0] trim;
    logic [15:0] mode_cfg;
    logic [15:0] turn_on_wait;
    logic [15:0] ramp_duration;
    logic [15:0] set_point;
    logic [15:0] to_limit;
    logic [7:0] to_action;
    logic [15:0] routing;
    logic [31:0] rdata;
    logic run_oe;
    logic tb_oe;
    logic fault_oe;
    logic force_dcm;
    logic ls_off;
    logic servo_on;
    logic ccm;
    logic [15:0] flt_cnt;
    logic flt_lvl;
  } orss_st_t;

endpackage

// >>> bench/orss_peer.sv
// Purpose: peer converter sharing the run and timebase wires
// Assumes: both wires carry pull-ups; every party only pulls low
// Notes:   peer heartbeat is faster than the device's own one
`timescale 1ns/100ps

module orss_peer #(
  parameter int PERIOD = 16,
  parameter int LOW = 2
) (
  input wire logic mclk,
  input wire logic hold_run,
  input wire logic run_oe,
  input wire logic timebase_oe,
  output logic run_line,
  output logic timebase
);
  int cnt = 0;

  //////////////////////////////////////////////////////////////////////
  // Free-running heartbeat; being fastest, it paces every party
  always @(posedge mclk) begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
  end

  // Wired lines: a pull-up wins only when nobody pulls low
  assign timebase = !(timebase_oe || cnt < LOW);
  assign run_line = !(run_oe || hold_run);
endmodule

// >>> bench/testbench.sv
// Purpose: self-checking bench of the output ramp sequencer
// Assumes: peer model paces ticks every 16 clocks
// Notes:   tick and filter counts shortened by parameters
`timescale 1ns/100ps

`include "orss_regs.svh"

module testbench;
  import orss_pkg::*;

  logic mclk = 1'h0;
  logic reset = 1'h1;
  orss_bus_t bus = '0;
  logic [31:0] rdata;
  logic [31:0] st;
  logic init_done = 1'h0, supply_ok = 1'h0, fault_pin = 1'h1;
  logic vout_above = 1'h0, uv_fault = 1'h0, oc_active = 1'h0;
  logic rev_current = 1'h0, adc_low = 1'h0, adc_high = 1'h0;
  logic hold_run = 1'h1;
  logic run_line, timebase, run_oe, timebase_oe, fault_oe, lsb_fine;
  logic force_dcm, ccm_mode, low_side_off, servo_on;
  logic [15:0] target;
  logic [11:0] dac_trim;
  orss_in_t pins;
  int n_errors = 0;
  int checks = 0;
  int steps;
  int t0;
  logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
    8'h24};
  logic [31:0] rv [8] = '{32'h1, 32'h0, 32'h50, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0};

  assign pins = {init_done, supply_ok, run_line, timebase, fault_pin,
    vout_above, uv_fault, oc_active, rev_current, adc_low, adc_high};

  always #2 mclk = ~mclk;

  orss_seq #(.TICK_CYCLES(20), .FLT_CYCLES(8), .TB_LOW_CYCLES(2)) i_orss_seq (
    .mclk(mclk), .reset(reset), .bus(bus), .rdata(rdata), .pins(pins),
    .run_oe(run_oe), .timebase_oe(timebase_oe), .fault_oe(fault_oe),
    .target(target), .dac_trim(dac_trim), .lsb_fine(lsb_fine),
    .force_dcm(force_dcm), .ccm_mode(ccm_mode),
    .low_side_off(low_side_off), .servo_on(servo_on)
  );

  orss_peer #(.PERIOD(16), .LOW(2)) i_orss_peer (
    .mclk(mclk), .hold_run(hold_run), .run_oe(run_oe),
    .timebase_oe(timebase_oe), .run_line(run_line), .timebase(timebase)
  );

  //////////////////////////////////////////////////////////////////////
  // Compare and count; an unknown never passes
  task automatic chk(input string nm, input logic [31:0] exp,
    input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      n_errors++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // One-cycle strobes, launched just after an edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'h1;
    @(posedge mclk);
    bus.wr <= 1'h0;
  endtask

  // Read data stand from the edge that samples the strobe until the next read
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd <= 1'h1;
    @(posedge mclk);
    bus.rd <= 1'h0;
    #1;
    d = rdata;
  endtask

  task automatic wait_servo(input logic exp, input int n);
    for (int i = 0; i < n && servo_on !== exp; i++) begin
      @(posedge mclk);
      #1;
    end
    #1;
    chk("servo_on", exp, servo_on);
  endtask

  // Restart from init, release the run wire and follow the target
  task automatic start_seq(input logic [15:0] sp, input logic [15:0] dur);
    logic [15:0] prev;
    logic [15:0] first;
    supply_ok <= 1'h0;
    hold_run <= 1'h1;
    cyc(6);
    chk("target idle", 32'h0, target);
    wr(`ORSS_A_SET_POINT, {16'h0, sp});
    wr(`ORSS_A_RAMP_DURATION, {16'h0, dur});
    supply_ok <= 1'h1;
    cyc(8);
    chk("run_oe", 32'h0, run_oe);
    chk("run_line", 32'h0, run_line);
    rd(`ORSS_A_STATUS, st);
    chk("state", 32'h1, st[9:7]);
    hold_run <= 1'h0;
    steps = 0;
    prev = 16'h0;
    first = 16'h0;
    t0 = 0;
    for (int i = 0; i < 4000 && target !== sp; i++) begin
      @(posedge mclk);
      #1;
      if (target !== prev) begin
        steps++;
        if (steps == 1) begin
          first = target;
          t0 = i;
        end
        if (target !== sp) chk("force_dcm", 32'h1, force_dcm);
      end
      prev = target;
    end
    chk("target end", sp, target);
    chk("steps", (dur < 3) ? 1 : dur, steps);
    chk("wait", 32'h1, t0 > 16);
    if (dur >= 3) chk("first step", sp / dur, first);
  endtask

  task automatic results;
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'h0;
    cyc(1);
    chk("run_oe rst", 32'h1, run_oe);
    foreach (ra[i]) begin
      rd(ra[i], st);
      chk("reg reset", rv[i], st);
    end
    wr(`ORSS_A_TARGET, 32'hFFFF);
    rd(`ORSS_A_TARGET, st);
    chk("target ro", 32'h0, st);
    supply_ok <= 1'h1;
    cyc(10);
    chk("run_oe no init", 32'h1, run_oe);
    rev_current <= 1'h1;
    cyc(5);
    chk("low_side_off", 32'h1, low_side_off);
    rev_current <= 1'h0;
    init_done <= 1'h1;
    $display("test reset done");
    // Servo enable set here stays on for every later sequence
    wr(`ORSS_A_MODE_CFG, 32'h41);
    wr(`ORSS_A_TURN_ON_WAIT, 32'h2);
    vout_above <= 1'h1;
    start_seq(16'h0064, 16'h0004);
    wait_servo(1'h1, 200);
    chk("force_dcm run", 32'h0, force_dcm);
    chk("ccm_mode", 32'h1, ccm_mode);
    rev_current <= 1'h1;
    cyc(5);
    chk("low_side_off ccm", 32'h0, low_side_off);
    rev_current <= 1'h0;
    adc_low <= 1'h1;
    for (t0 = 0; t0 < 16000 && dac_trim === 12'h0; t0++) begin
      @(posedge mclk);
      #1;
    end
    chk("trim", 32'h1, dac_trim);
    chk("servo period", 32'h1, t0 > 12800);
    chk("timebase_oe", 32'h0, timebase_oe);
    adc_low <= 1'h0;
    wr(`ORSS_A_MODE_CFG, 32'h43);
    cyc(2);
    chk("lsb_fine", 32'h1, lsb_fine);
    $display("test ramp and servo done");
    oc_active <= 1'h1;
    start_seq(16'h0064, 16'h0002);
    cyc(100);
    chk("servo oc", 32'h0, servo_on);
    oc_active <= 1'h0;
    wait_servo(1'h1, 50);
    $display("test skip done");
    wr(`ORSS_A_TIMEOUT_LIMIT, 32'h14);
    vout_above <= 1'h0;
    oc_active <= 1'h1;
    start_seq(16'h003C, 16'h0003);
    cyc(400);
    chk("servo ign", 32'h0, servo_on);
    oc_active <= 1'h0;
    wait_servo(1'h1, 50);
    wr(`ORSS_A_TIMEOUT_ACTION, 32'h80);
    vout_above <= 1'h1;
    start_seq(16'h003C, 16'h0003);
    cyc(40);
    chk("servo early", 32'h0, servo_on);
    uv_fault <= 1'h1;
    cyc(400);
    chk("servo uv", 32'h0, servo_on);
    uv_fault <= 1'h0;
    wait_servo(1'h1, 50);
    $display("test timeout done");
    wr(`ORSS_A_FAULT_ROUTING, 32'h1000);
    vout_above <= 1'h0;
    cyc(6);
    chk("fault_oe low", 32'h1, fault_oe);
    vout_above <= 1'h1;
    cyc(6);
    chk("fault_oe good", 32'h0, fault_oe);
    fault_pin <= 1'h0;
    cyc(3);
    rd(`ORSS_A_STATUS, st);
    chk("glitch", 32'h1, st[6]);
    fault_pin <= 1'h1;
    cyc(12);
    rd(`ORSS_A_STATUS, st);
    chk("glitch after", 32'h1, st[6]);
    fault_pin <= 1'h0;
    cyc(20);
    rd(`ORSS_A_STATUS, st);
    chk("filtered", 32'h0, st[6]);
    $display("test fault pin done");
    results();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    n_errors++;
    $display("unexpected watchdog: expected finish, seen hang");
    results();
  end
endmodule
